// ==== include/sirpc_pkg.sv ====
// Constants, types and decode helpers for the serial infrared pulse codec.
// Assumes a 125 MHz system clock; the crystal is modelled by a clock divider.
package sirpc_pkg;

  localparam int CLK_HZ  = 125_000_000;
  localparam int XTAL_HZ = 3_686_400;
  // Nearest whole count of system clocks per emulated crystal cycle.
  localparam int XTAL_CLKS = (CLK_HZ + XTAL_HZ / 2) / XTAL_HZ;
  localparam logic [5:0] XTAL_LAST = 6'(XTAL_CLKS - 1);

  localparam logic [3:0] CELL_LAST  = 4'hF;
  localparam logic [3:0] CELL_HALF  = 4'h8;
  localparam logic [2:0] PW_316     = 3'h3;
  localparam logic [2:0] PW_FIXED   = 3'h6;
  localparam logic [3:0] IDLE_CELLS = 4'hA;

  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int CTRL_RATE    = 0;
  localparam int CTRL_CLK_SEL = 3;
  localparam int CTRL_FIXED   = 4;
  localparam int CTRL_PD      = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int ST_OVR = 3;

  localparam int SY_TX   = 0;
  localparam int SY_IR   = 1;
  localparam int SY_BAUD = 2;
  localparam int SY_RST  = 3;
  localparam int SY_N    = 4;
  // Idle levels: serial line high, codec reset released, others low.
  localparam logic [3:0] SYNC_IDLE = 4'h9;

  typedef enum logic [0:0] {ENC_IDLE, ENC_PULSE} sirpc_enc_t;
  typedef enum logic [0:0] {DEC_IDLE, DEC_RUN} sirpc_dec_t;

  // Crystal cycles per 16x baud tick for each rate_select code.
  function automatic logic [4:0] sirpc_rate_div(input logic [2:0] sel);
    case (sel)
      3'h0:    sirpc_rate_div = 5'h02;
      3'h1:    sirpc_rate_div = 5'h04;
      3'h2:    sirpc_rate_div = 5'h06;
      3'h3:    sirpc_rate_div = 5'h0C;
      default: sirpc_rate_div = 5'h18;
    endcase
  endfunction

endpackage

// ==== src/sirpc_codec.sv ====
// Serial infrared pulse encoder and decoder with an Avalon-MM control slave.
// Assumes the UART and transceiver pins are asynchronous to clk.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module sirpc_codec
  import sirpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        uart_serial_output,
  output logic             uart_serial_input,
  input  wire logic        ir_pulse_in,
  output logic             ir_pulse_out,
  input  wire logic        baud_x16_clock_in,
  input  wire logic        codec_reset_n,
  output logic             rx_bit_data,
  output logic             rx_bit_valid,
  input  wire logic        rx_bit_ready
);

  logic [SY_N-1:0] pins;
  logic [2:0]      sync_q [SY_N];
  logic [2:0]      sync_d [SY_N];
  logic [SY_N-1:0] lvl_q;
  logic [SY_N-1:0] lvl_d;

  assign pins = {codec_reset_n, baud_x16_clock_in, ir_pulse_in, uart_serial_output};

  // A change counts only once the second and third stages agree.
  for (genvar i = 0; i < SY_N; i++) begin : g_sync
    always_comb begin
      sync_d[i] = {sync_q[i][1:0], pins[i]};
      lvl_d[i]  = (sync_q[i][1] == sync_q[i][2]) ? sync_q[i][2] : lvl_q[i];
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync_q[i] <= {3{SYNC_IDLE[i]}};
        lvl_q[i]  <= SYNC_IDLE[i];
      end else begin
        sync_q[i] <= sync_d[i];
        lvl_q[i]  <= lvl_d[i];
      end
    end
  end

  logic tx_fall;
  logic ir_rise;
  logic baud_rise;
  logic st_rst;

  assign tx_fall   = lvl_q[SY_TX] & ~lvl_d[SY_TX];
  assign ir_rise   = ~lvl_q[SY_IR] & lvl_d[SY_IR];
  assign baud_rise = ~lvl_q[SY_BAUD] & lvl_d[SY_BAUD];
  assign st_rst    = ~lvl_q[SY_RST];

  logic [5:0] ctrl_q;
  logic [5:0] ctrl_d;
  logic [5:0] osc_cnt_q;
  logic [5:0] osc_cnt_d;
  logic [4:0] div_cnt_q;
  logic [4:0] div_cnt_d;
  logic [4:0] div_last;
  logic       osc_on;
  logic       xtal_tick;
  logic       int_tick;
  logic       tick;
  logic       fixed;

  assign fixed    = ctrl_q[CTRL_FIXED];
  assign div_last = 5'(sirpc_rate_div(ctrl_q[CTRL_RATE +: 3]) - 5'h01);

  always_comb begin
    osc_on    = ~ctrl_q[CTRL_CLK_SEL] & ~ctrl_q[CTRL_PD];
    xtal_tick = osc_on && (osc_cnt_q == XTAL_LAST);
    osc_cnt_d = (!osc_on || xtal_tick) ? 6'h00 : 6'(osc_cnt_q + 6'h01);
    int_tick  = xtal_tick && (div_cnt_q == div_last);
    div_cnt_d = div_cnt_q;
    if (!osc_on) begin
      div_cnt_d = 5'h00;
    end else if (xtal_tick) begin
      div_cnt_d = (div_cnt_q >= div_last) ? 5'h00 : 5'(div_cnt_q + 5'h01);
    end
    // External 16x clock acts on its rising edges only.
    tick = ctrl_q[CTRL_CLK_SEL] ? baud_rise : int_tick;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_q <= 6'h00;
      div_cnt_q <= 5'h00;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      div_cnt_q <= div_cnt_d;
    end
  end

  sirpc_enc_t enc_q;
  sirpc_enc_t enc_d;
  logic [3:0] ecell_q;
  logic [3:0] ecell_d;
  logic [2:0] pw_q;
  logic [2:0] pw_d;
  logic       irout_q;
  logic       irout_d;
  logic       pw_step;
  logic [2:0] pw_lim;

  always_comb begin
    enc_d   = enc_q;
    ecell_d = ecell_q;
    pw_d    = pw_q;
    irout_d = irout_q;
    pw_step = fixed ? xtal_tick : tick;
    pw_lim  = fixed ? PW_FIXED : PW_316;
    if (st_rst) begin
      enc_d   = ENC_IDLE;
      ecell_d = 4'h0;
      pw_d    = 3'h0;
      irout_d = 1'b0;
    end else begin
      unique case (enc_q)
        ENC_IDLE: begin
          if (tx_fall) begin
            enc_d   = ENC_PULSE;
            ecell_d = 4'h0;
            pw_d    = 3'h0;
            irout_d = 1'b1;
          end
        end
        ENC_PULSE: begin
          if (irout_q && pw_step) begin
            pw_d = 3'(pw_q + 3'h1);
            if (pw_d == pw_lim) begin
              irout_d = 1'b0;
            end
          end
          if (tick) begin
            ecell_d = 4'(ecell_q + 4'h1);
          end
          // Each further low bit cell gets its own pulse.
          if (tx_fall || (tick && ecell_q == CELL_LAST)) begin
            if (tx_fall || !lvl_q[SY_TX]) begin
              ecell_d = 4'h0;
              pw_d    = 3'h0;
              irout_d = 1'b1;
            end else begin
              enc_d   = ENC_IDLE;
              irout_d = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_q   <= ENC_IDLE;
      ecell_q <= 4'h0;
      pw_q    <= 3'h0;
      irout_q <= 1'b0;
    end else begin
      enc_q   <= enc_d;
      ecell_q <= ecell_d;
      pw_q    <= pw_d;
      irout_q <= irout_d;
    end
  end

  sirpc_dec_t dec_q;
  sirpc_dec_t dec_d;
  logic [3:0] dcell_q;
  logic [3:0] dcell_d;
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  logic       seen_q;
  logic       seen_d;
  logic       rxout_q;
  logic       rxout_d;
  logic       push_req;
  logic       push_bit;

  // Pulse width is not measured, so both pulse formats decode alike.
  always_comb begin
    dec_d    = dec_q;
    dcell_d  = dcell_q;
    idle_d   = idle_q;
    seen_d   = seen_q;
    rxout_d  = rxout_q;
    push_req = 1'b0;
    push_bit = ~seen_q;
    if (st_rst) begin
      dec_d   = DEC_IDLE;
      dcell_d = 4'h0;
      idle_d  = 4'h0;
      seen_d  = 1'b0;
      rxout_d = 1'b1;
    end else begin
      unique case (dec_q)
        DEC_IDLE: begin
          if (ir_rise) begin
            dec_d   = DEC_RUN;
            dcell_d = 4'h0;
            idle_d  = 4'h0;
            seen_d  = 1'b1;
            rxout_d = 1'b0;
          end
        end
        DEC_RUN: begin
          if (tick) begin
            dcell_d = 4'(dcell_q + 4'h1);
          end
          if (ir_rise) begin
            // A late cell is closed first; an early pulse only realigns.
            push_req = (dcell_q >= CELL_HALF);
            dcell_d  = 4'h0;
            idle_d   = 4'h0;
            seen_d   = 1'b1;
            rxout_d  = 1'b0;
          end else if (tick && dcell_q == CELL_LAST) begin
            push_req = 1'b1;
            seen_d   = 1'b0;
            rxout_d  = 1'b1;
            idle_d   = seen_q ? 4'h0 : 4'(idle_q + 4'h1);
            if (!seen_q && idle_d == IDLE_CELLS) begin
              dec_d = DEC_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_q   <= DEC_IDLE;
      dcell_q <= 4'h0;
      idle_q  <= 4'h0;
      seen_q  <= 1'b0;
      rxout_q <= 1'b1;
    end else begin
      dec_q   <= dec_d;
      dcell_q <= dcell_d;
      idle_q  <= idle_d;
      seen_q  <= seen_d;
      rxout_q <= rxout_d;
    end
  end

  // Two-entry buffer: an output stage and a spare that absorbs one stall.
  logic out_v_q;
  logic out_v_d;
  logic out_b_q;
  logic out_b_d;
  logic sp_v_q;
  logic sp_v_d;
  logic sp_b_q;
  logic sp_b_d;
  logic overrun;

  always_comb begin
    out_v_d = out_v_q;
    out_b_d = out_b_q;
    sp_v_d  = sp_v_q;
    sp_b_d  = sp_b_q;
    if (out_v_q && rx_bit_ready) begin
      out_v_d = 1'b0;
    end
    if (!out_v_d && sp_v_d) begin
      out_v_d = 1'b1;
      out_b_d = sp_b_q;
      sp_v_d  = 1'b0;
    end
    // The decoder cannot pause the line, so a full buffer is flagged.
    // A slot drained in this cycle is reused at once, so only a truly full buffer drops a bit.
    overrun = push_req & sp_v_d;
    if (push_req && !sp_v_d) begin
      if (!out_v_d) begin
        out_v_d = 1'b1;
        out_b_d = push_bit;
      end else begin
        sp_v_d = 1'b1;
        sp_b_d = push_bit;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_v_q <= 1'b0;
      out_b_q <= 1'b1;
      sp_v_q  <= 1'b0;
      sp_b_q  <= 1'b1;
    end else begin
      out_v_q <= out_v_d;
      out_b_q <= out_b_d;
      sp_v_q  <= sp_v_d;
      sp_b_q  <= sp_b_d;
    end
  end

  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ovr_q;
  logic        ovr_d;
  logic        do_wr;
  logic [4:0]  status;

  assign status = {rxout_q, ovr_q, dec_q == DEC_RUN, enc_q == ENC_PULSE, osc_on};

  // One wait cycle, then the answer; a write lands on the answering edge.
  always_comb begin
    wait_d  = ~(wait_q & (avs_read | avs_write));
    do_wr   = avs_write & ~wait_q & avs_byteenable[0];
    rdata_d = rdata_q;
    if (wait_q && (avs_read || avs_write)) begin
      unique case (avs_address)
        REG_CTRL:   rdata_d = {26'h0000000, ctrl_q};
        REG_STATUS: rdata_d = {27'h0000000, status};
        default:    rdata_d = 32'h00000000;
      endcase
    end
    ctrl_d = (do_wr && avs_address == REG_CTRL) ? avs_writedata[5:0] : ctrl_q;
    // A new overrun wins over a clear in the same cycle.
    ovr_d  = overrun | (ovr_q & ~(do_wr && avs_address == REG_STATUS && avs_writedata[ST_OVR]));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q  <= CTRL_RST;
      ovr_q   <= 1'b0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      ovr_q   <= ovr_d;
    end
  end

  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
  assign uart_serial_input = rxout_q;
  assign ir_pulse_out      = irout_q;
  assign rx_bit_data       = out_b_q;
  assign rx_bit_valid      = out_v_q;

  logic [8:0] hi_len_q;
  localparam int FIX_MIN = (int'(PW_FIXED) - 1) * XTAL_CLKS;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_len_q <= 9'h000;
    end else begin
      hi_len_q <= !irout_q ? 9'h000 : (&hi_len_q ? hi_len_q : 9'(hi_len_q + 9'h001));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_tx_pulse;
    tx_fall && !st_rst |=> ir_pulse_out;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("no pulse after tx fall");

  property p_rx_low;
    ir_rise && !st_rst |=> !uart_serial_input;
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("rx not low after ir pulse");

  property p_pw_limit;
    ir_pulse_out |-> pw_q < (fixed ? PW_FIXED : PW_316);
  endproperty
  a_pw_limit: assert property (p_pw_limit) else $error("pulse past its width");

  sequence s_fix_end;
    $fell(ir_pulse_out) && fixed && osc_on && !st_rst;
  endsequence
  property p_fix_width;
    s_fix_end |-> hi_len_q >= FIX_MIN;
  endproperty
  a_fix_width: assert property (p_fix_width) else $error("fixed pulse too short");

  property p_ext_pd;
    ctrl_q[CTRL_CLK_SEL] && $past(ctrl_q[CTRL_CLK_SEL]) |-> osc_cnt_q == 6'h00 && !osc_on;
  endproperty
  a_ext_pd: assert property (p_ext_pd) else $error("oscillator runs in external mode");

  property p_pd_only;
    ctrl_q[CTRL_PD] && !ctrl_q[CTRL_CLK_SEL] && baud_rise |-> !xtal_tick && !tick;
  endproperty
  a_pd_only: assert property (p_pd_only) else $error("power down leaks ticks");

  property p_rst_idle;
    st_rst |=> enc_q == ENC_IDLE && dec_q == DEC_IDLE && !ir_pulse_out && uart_serial_input;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("codec reset not honoured");

  property p_tick_gap;
    int_tick |=> !int_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("internal ticks too close");

  property p_ext_edge;
    ctrl_q[CTRL_CLK_SEL] && enc_q == ENC_PULSE && baud_rise && !tx_fall && !st_rst && ecell_q != CELL_LAST
      |=> ecell_q == 4'($past(ecell_q) + 4'h1);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("tick not from external rise");

endmodule

// ==== verification/sirpc_far_model.sv ====
// Far side of the codec: the host UART transmit line, the optical transceiver and the bit consumer.
// Assumes its tasks are called from the bench right after a rising edge of clk.
`timescale 1ns/1ps
module sirpc_far_model (
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic rx_bit_valid,
  input  wire logic rx_bit_data,
  output logic      rx_bit_ready,
  output logic      uart_serial_output,
  output logic      ir_pulse_in
);
  logic got_q[$];

  initial begin
    uart_serial_output = 1'b1;
    ir_pulse_in        = 1'b0;
  end

  // A stalled consumer lets the codec buffer fill up.
  assign rx_bit_ready = !stall;

  always @(posedge clk) begin
    if (rx_bit_valid === 1'b1 && rx_bit_ready) begin
      got_q.push_back(rx_bit_data);
    end
  end

  // The line falls for n cycles and then returns to its idle high level.
  task automatic tx_low(input int n);
    uart_serial_output <= 1'b0;
    repeat (n) @(posedge clk);
    uart_serial_output <= 1'b1;
  endtask

  task automatic ir_pulse(input int n);
    ir_pulse_in <= 1'b1;
    repeat (n) @(posedge clk);
    ir_pulse_in <= 1'b0;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial infrared pulse codec.
// Assumes the codec answers Avalon requests itself and a far-side model sits on its lines.
`timescale 1ns/1ps
module tb_top
  import sirpc_pkg::*;
;
  localparam int CELL = 16 * 4 * XTAL_CLKS;
  logic        clk = 1'b0;
  logic        arst_n, codec_reset_n, stall, baud_x16_clock_in;
  logic [1:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [3:0]  avs_byteenable, ext_cnt;
  logic        uart_serial_output, uart_serial_input, ir_pulse_in, ir_pulse_out;
  logic        rx_bit_data, rx_bit_valid, rx_bit_ready;
  int          error_cnt, checks, w;
  int          divs[5] = '{2, 4, 6, 12, 24};

  sirpc_codec sirpc_codec_i (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uart_serial_output(uart_serial_output),
    .uart_serial_input(uart_serial_input), .ir_pulse_in(ir_pulse_in), .ir_pulse_out(ir_pulse_out),
    .baud_x16_clock_in(baud_x16_clock_in), .codec_reset_n(codec_reset_n), .rx_bit_data(rx_bit_data),
    .rx_bit_valid(rx_bit_valid), .rx_bit_ready(rx_bit_ready));
  sirpc_far_model sirpc_far_model_i (.clk(clk), .stall(stall), .rx_bit_valid(rx_bit_valid),
    .rx_bit_data(rx_bit_data), .rx_bit_ready(rx_bit_ready), .uart_serial_output(uart_serial_output),
    .ir_pulse_in(ir_pulse_in));

  always #4 clk = ~clk;

  // External 16x clock with a period of 32 system clocks.
  always @(posedge clk) begin
    ext_cnt <= ext_cnt + 4'h1;
    if (ext_cnt == 4'hF) begin
      baud_x16_clock_in <= ~baud_x16_clock_in;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic av_xfer(input logic wr, input logic [1:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    chk_rng(n, 1, 49);
  endtask

  task automatic measure_pulse(output int width);
    int n;
    n = 0;
    width = 0;
    while (ir_pulse_out !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    while (ir_pulse_out === 1'b1 && width < 20000) begin
      @(posedge clk);
      width++;
    end
  endtask

  task automatic wait_bits(input int k);
    int n;
    n = 0;
    while (sirpc_far_model_i.got_q.size() < k && n < 3 * CELL) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_regs();
    av_xfer(1'b0, REG_CTRL, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    av_xfer(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk(rdat & 32'h1F, 32'h11);
    av_xfer(1'b1, REG_CTRL, 32'h3F, 4'hE);
    av_xfer(1'b1, 2'h2, 32'h3F, 4'hF);
    av_xfer(1'b0, 2'h2, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    av_xfer(1'b0, REG_CTRL, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    av_xfer(1'b1, REG_CTRL, 32'hFFFF_FFFF, 4'hF);
    av_xfer(1'b0, REG_CTRL, 32'h0, 4'hF);
    chk(rdat, 32'h3F);
  endtask

  task automatic t_osc();
    logic [31:0] ctl[3] = '{32'h08, 32'h20, 32'h00};
    for (int i = 0; i < 3; i++) begin
      av_xfer(1'b1, REG_CTRL, ctl[i], 4'hF);
      // Long enough for external rising edges to arrive in every setting.
      repeat (64) @(posedge clk);
      av_xfer(1'b0, REG_STATUS, 32'h0, 4'hF);
      chk(rdat[0], (i == 2) ? 32'h1 : 32'h0);
    end
  endtask

  task automatic t_tx_rates();
    int exp;
    for (int r = 0; r < 5; r++) begin
      exp = PW_316 * divs[r] * XTAL_CLKS;
      av_xfer(1'b1, REG_CTRL, 32'(r), 4'hF);
      fork
        sirpc_far_model_i.tx_low(20);
        measure_pulse(w);
      join
      chk_rng(w, exp - divs[r] * XTAL_CLKS, exp + 4);
    end
  endtask

  task automatic t_fixed_ext();
    av_xfer(1'b1, REG_CTRL, 32'h11, 4'hF);
    fork
      sirpc_far_model_i.tx_low(20);
      measure_pulse(w);
    join
    chk_rng(w, (PW_FIXED - 1) * XTAL_CLKS, PW_FIXED * XTAL_CLKS + 4);
    // Fixed mode is dropped in the same write that chooses the external clock.
    av_xfer(1'b1, REG_CTRL, 32'h09, 4'hF);
    fork
      sirpc_far_model_i.tx_low(20);
      measure_pulse(w);
    join
    chk_rng(w, 2 * 32, 3 * 32 + 8);
  endtask

  task automatic t_creset();
    av_xfer(1'b1, REG_CTRL, 32'h01, 4'hF);
    fork
      sirpc_far_model_i.tx_low(20);
      sirpc_far_model_i.ir_pulse(30);
    join_none
    repeat (12) @(posedge clk);
    chk(ir_pulse_out, 32'h1);
    chk(uart_serial_input, 32'h0);
    codec_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(ir_pulse_out, 32'h0);
    chk(uart_serial_input, 32'h1);
    codec_reset_n <= 1'b1;
    repeat (CELL) @(posedge clk);
  endtask

  task automatic t_rx();
    sirpc_far_model_i.got_q.delete();
    sirpc_far_model_i.ir_pulse(PW_316 * 4 * XTAL_CLKS);
    wait_bits(2);
    chk(sirpc_far_model_i.got_q[0], 32'h0);
    chk(sirpc_far_model_i.got_q[1], 32'h1);
    sirpc_far_model_i.ir_pulse(PW_FIXED * XTAL_CLKS);
    wait_bits(3);
    chk(sirpc_far_model_i.got_q[2], 32'h0);
  endtask

  task automatic t_overrun();
    stall <= 1'b1;
    sirpc_far_model_i.got_q.delete();
    // Checks follow the last pulse closely, so no cell closes while the buffer drains.
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        repeat (CELL - PW_316 * 4 * XTAL_CLKS) @(posedge clk);
      end
      sirpc_far_model_i.ir_pulse(PW_316 * 4 * XTAL_CLKS);
    end
    av_xfer(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk(rdat & 32'h0C, 32'h0C);
    chk(rx_bit_valid, 32'h1);
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    chk(sirpc_far_model_i.got_q.size(), 32'h2);
    chk(sirpc_far_model_i.got_q[0], 32'h0);
    chk(rx_bit_valid, 32'h0);
    av_xfer(1'b1, REG_STATUS, 32'h08, 4'hF);
    repeat (11 * CELL) @(posedge clk);
    av_xfer(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk(rdat & 32'h0C, 32'h00);
  endtask

  initial begin
    arst_n = 1'b0;
    codec_reset_n = 1'b1;
    stall = 1'b0;
    baud_x16_clock_in = 1'b0;
    ext_cnt = 4'h0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    // The rate is written before the first traffic; t_rx and t_overrun keep the one t_creset writes.
    t_regs();
    t_osc();
    t_tx_rates();
    t_fixed_ext();
    t_creset();
    t_rx();
    t_overrun();
    give_verdict();
  end

  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
